//--- design/asf_defs.svh
// Constants for the asynchronous serial framing link: offsets, fields, codes.
// Assumes inclusion by asf_pkg and by each end of the link.
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH

// ----------------------------------------
// Register byte offsets (device end)
// ----------------------------------------
`define ASF_ADR_CTRL 8'h00
`define ASF_ADR_TXDATA 8'h04
`define ASF_ADR_RXDATA 8'h08
`define ASF_ADR_STATUS 8'h0c

// ----------------------------------------
// Control word fields and reset value
// ----------------------------------------
`define ASF_CTRL_LEN_LO 0
`define ASF_CTRL_PAR_LO 2
`define ASF_CTRL_STOP_LO 5
`define ASF_CTRL_FLOW 7
`define ASF_CTRL_DIV_LO 16
// 8 data bits, no parity, 1 stop, flow on, divisor 129 (about 9600 baud)
`define ASF_CTRL_RST 32'h0081_0083

// ----------------------------------------
// Status bits
// ----------------------------------------
`define ASF_ST_TX_FULL 0
`define ASF_ST_TX_BUSY 1
`define ASF_ST_PAUSED 2
`define ASF_ST_RX_VALID 3
`define ASF_ST_FRAME_ERR 4
`define ASF_ST_PAR_ERR 5
`define ASF_ST_OVERRUN 6

// ----------------------------------------
// Framing encodings and timing
// ----------------------------------------
`define ASF_PAR_NONE 3'h0
`define ASF_PAR_ODD 3'h1
`define ASF_PAR_EVEN 3'h2
`define ASF_PAR_MARK 3'h3
`define ASF_PAR_SPACE 3'h4
`define ASF_STOP_1 2'h0
`define ASF_STOP_1H5 2'h1
`define ASF_STOP_2 2'h2
`define ASF_OSR_LAST 6'h0f
`define ASF_HALF_LAST 6'h07
`define ASF_STOP15_LAST 6'h17
`define ASF_STOP2_LAST 6'h1f

// ----------------------------------------
// Flow control characters
// ----------------------------------------
`define ASF_DEVICE_CONTROL_ONE_CODE 8'h11
`define ASF_DEVICE_CONTROL_THREE_CODE 8'h13

`endif

//--- design/asf_pkg.sv
// Types and framing helpers shared by both ends of the serial link.
// Assumes asf_defs.svh on the include path.
`include "asf_defs.svh"

package asf_pkg;

  // ----------------------------------------
  // Bit-engine states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ASF_IDLE = 5'h01,
    ASF_START = 5'h02,
    ASF_DATA = 5'h04,
    ASF_PAR = 5'h08,
    ASF_STOP = 5'h10
  } asf_state_t;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic asf_parity(input logic [7:0] d, input logic [1:0] len,
                                      input logic [2:0] mode);
    logic x;
    x = ^(d & (8'hff >> (2'h3 - len)));
    if (mode == `ASF_PAR_ODD) return ~x;
    else if (mode == `ASF_PAR_EVEN) return x;
    else if (mode == `ASF_PAR_MARK) return 1'b1;
    else return 1'b0;
  endfunction

  function automatic logic [5:0] asf_stop_last(input logic [1:0] stop);
    if (stop == `ASF_STOP_1H5) return `ASF_STOP15_LAST;
    else if (stop == `ASF_STOP_2) return `ASF_STOP2_LAST;
    else return `ASF_OSR_LAST;
  endfunction

endpackage

//--- design/asf_link_if.sv
// Two serial lines between the device end and the peer end.
// Both lines idle high (mark); each end drives one of them.
`timescale 1ns/1ps

interface asf_link_if;
  logic d2p;
  logic p2d;
  modport dev (output d2p, input p2d);
  modport peer (input d2p, output p2d);
endinterface

//--- design/asf_dev.sv
// Device end: framed serial transmitter and receiver with pause/resume flow.
// Assumes a classic Wishbone master and the peer end on asf_link_if.
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "asf_defs.svh"

// Overview of operation
// R1: Time bits from 16x oversample clock
// R2: Order: start, data, parity, stop
// R3: Start bit is always low
// R4: Data length selectable 5 to 8
// R5: One sent as mark, zero as space
// R6: Data bits least significant first
// R7: Odd parity makes mark count odd
// R8: Even parity makes mark count even
// R9: No parity: stop follows last data
// R10: Mark parity bit always high
// R11: Space parity bit always low
// R12: Stop bits high; 1, 1.5 or 2
// R13: Hunt next start at stop midpoint
// R14: One-stop receiver accepts two stops
// R15: Low stop sample flags framing error
// R16: Pause code halts transmission until resume
// R17: Resume code restarts where paused
// R18: Resume ignored unless currently paused
// R19: Doubled control code may mean data; here each clean flow code is consumed while flow is on, doubled or not
// R20: Confirm start, sample bits at centre
module asf_dev
  import asf_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Serial link
  asf_link_if.dev lnk
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] baud_cnt;
    logic [7:0] tx_hold;
    logic tx_full;
    asf_state_t tx_st;
    logic [5:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic tx_line;
    logic rx_s1;
    logic rx_s2;
    asf_state_t rx_st;
    logic [5:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_perr;
    logic rx_ferr;
    logic rx_second;
    logic [7:0] rx_data;
    logic rx_valid;
    logic frame_err;
    logic par_err;
    logic overrun;
    logic paused;
    logic ack;
    logic [31:0] rdat;
  } asf_dev_st_t;

  asf_dev_st_t s;
  asf_dev_st_t next_s;

  logic [1:0] len;
  logic [2:0] par;
  logic [1:0] stop;
  logic tick;
  logic [2:0] last_bit;
  logic req;
  logic [7:0] rx_word;

  assign len = s.ctrl[`ASF_CTRL_LEN_LO +: 2];
  assign par = s.ctrl[`ASF_CTRL_PAR_LO +: 3];
  assign stop = s.ctrl[`ASF_CTRL_STOP_LO +: 2];
  assign tick = (s.baud_cnt == 16'h0000);
  assign last_bit = {1'b0, len} + 3'h4;
  assign req = i_wb_cyc & i_wb_stb;
  // Shifted in at the top, so realign short characters
  assign rx_word = s.rx_sh >> (2'h3 - len);

  assign o_wb_ack = s.ack;
  assign o_wb_dat = s.rdat;
  assign lnk.d2p = s.tx_line;

  always_comb begin
    next_s = s;
    // ----------------------------------------
    // Oversample clock
    // ----------------------------------------
    next_s.baud_cnt = tick ? s.ctrl[`ASF_CTRL_DIV_LO +: 16] : s.baud_cnt - 16'h0001; // [R1]

    // ----------------------------------------
    // Bus slave: answer one cycle after request, act on the ack edge
    // ----------------------------------------
    next_s.ack = req & ~s.ack;
    if (req & ~s.ack) begin
      unique case (i_wb_adr)
        `ASF_ADR_CTRL: next_s.rdat = s.ctrl;
        `ASF_ADR_RXDATA: next_s.rdat = {24'h00_0000, s.rx_data};
        `ASF_ADR_STATUS: begin
          next_s.rdat = 32'h0000_0000;
          next_s.rdat[`ASF_ST_TX_FULL] = s.tx_full;
          next_s.rdat[`ASF_ST_TX_BUSY] = (s.tx_st != ASF_IDLE);
          next_s.rdat[`ASF_ST_PAUSED] = s.paused;
          next_s.rdat[`ASF_ST_RX_VALID] = s.rx_valid;
          next_s.rdat[`ASF_ST_FRAME_ERR] = s.frame_err;
          next_s.rdat[`ASF_ST_PAR_ERR] = s.par_err;
          next_s.rdat[`ASF_ST_OVERRUN] = s.overrun;
        end
        default: next_s.rdat = 32'h0000_0000;
      endcase
    end
    if (req & s.ack & i_wb_we) begin
      if (i_wb_adr == `ASF_ADR_CTRL) begin
        for (int b = 0; b < 4; b++) begin
          if (i_wb_sel[b]) next_s.ctrl[8*b +: 8] = i_wb_dat[8*b +: 8];
        end
      end
      // A write while the holding byte is full is dropped
      if (i_wb_adr == `ASF_ADR_TXDATA && i_wb_sel[0] && !s.tx_full) begin
        next_s.tx_hold = i_wb_dat[7:0];
        next_s.tx_full = 1'b1;
      end
      // Error flags clear by writing one
      if (i_wb_adr == `ASF_ADR_STATUS && i_wb_sel[0]) begin
        if (i_wb_dat[`ASF_ST_FRAME_ERR]) next_s.frame_err = 1'b0;
        if (i_wb_dat[`ASF_ST_PAR_ERR]) next_s.par_err = 1'b0;
        if (i_wb_dat[`ASF_ST_OVERRUN]) next_s.overrun = 1'b0;
      end
    end
    if (req & s.ack & ~i_wb_we & (i_wb_adr == `ASF_ADR_RXDATA)) next_s.rx_valid = 1'b0;

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    if (tick) begin
      next_s.tx_cnt = s.tx_cnt + 6'h01;
      unique case (s.tx_st)
        ASF_IDLE: begin
          next_s.tx_line = 1'b1;
          next_s.tx_cnt = 6'h00;
          // A pause only holds off the next character; the held byte waits
          if (s.tx_full && !s.paused) begin // [R16] [R17]
            next_s.tx_sh = s.tx_hold;
            next_s.tx_par = asf_parity(s.tx_hold, len, par); // [R7] [R8] [R10] [R11]
            next_s.tx_full = 1'b0;
            next_s.tx_st = ASF_START;
            next_s.tx_line = 1'b0; // [R3]
          end
        end
        ASF_START: begin
          if (s.tx_cnt == `ASF_OSR_LAST) begin // [R2]
            next_s.tx_cnt = 6'h00;
            next_s.tx_bit = 3'h0;
            next_s.tx_st = ASF_DATA;
            next_s.tx_line = s.tx_sh[0]; // [R5] [R6]
          end
        end
        ASF_DATA: begin
          if (s.tx_cnt == `ASF_OSR_LAST) begin
            next_s.tx_cnt = 6'h00;
            if (s.tx_bit == last_bit) begin // [R4]
              next_s.tx_st = (par == `ASF_PAR_NONE) ? ASF_STOP : ASF_PAR; // [R9]
              next_s.tx_line = (par == `ASF_PAR_NONE) ? 1'b1 : s.tx_par;
            end else begin
              next_s.tx_bit = s.tx_bit + 3'h1;
              next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
              next_s.tx_line = s.tx_sh[1]; // [R6]
            end
          end
        end
        ASF_PAR: begin
          if (s.tx_cnt == `ASF_OSR_LAST) begin
            next_s.tx_cnt = 6'h00;
            next_s.tx_st = ASF_STOP;
            next_s.tx_line = 1'b1; // [R12]
          end
        end
        ASF_STOP: begin
          if (s.tx_cnt == asf_stop_last(stop)) begin // [R12]
            next_s.tx_cnt = 6'h00;
            next_s.tx_st = ASF_IDLE;
          end
        end
      endcase
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    next_s.rx_s1 = lnk.p2d;
    next_s.rx_s2 = s.rx_s1;
    if (tick) begin
      next_s.rx_cnt = s.rx_cnt + 6'h01;
      unique case (s.rx_st)
        ASF_IDLE: begin
          next_s.rx_cnt = 6'h00;
          if (!s.rx_s2) next_s.rx_st = ASF_START; // [R3]
        end
        ASF_START: begin
          if (s.rx_cnt == `ASF_HALF_LAST) begin // [R20]
            next_s.rx_cnt = 6'h00;
            next_s.rx_bit = 3'h0;
            next_s.rx_perr = 1'b0;
            next_s.rx_ferr = 1'b0;
            next_s.rx_second = 1'b0;
            next_s.rx_st = s.rx_s2 ? ASF_IDLE : ASF_DATA;
          end
        end
        ASF_DATA: begin
          if (s.rx_cnt == `ASF_OSR_LAST) begin // [R20]
            next_s.rx_cnt = 6'h00;
            next_s.rx_sh = {s.rx_s2, s.rx_sh[7:1]}; // [R5] [R6]
            next_s.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == last_bit) begin // [R4]
              next_s.rx_st = (par == `ASF_PAR_NONE) ? ASF_STOP : ASF_PAR; // [R9]
            end
          end
        end
        ASF_PAR: begin
          if (s.rx_cnt == `ASF_OSR_LAST) begin
            next_s.rx_cnt = 6'h00;
            next_s.rx_perr = (s.rx_s2 != asf_parity(rx_word, len, par)); // [R7] [R8] [R10] [R11]
            next_s.rx_st = ASF_STOP;
          end
        end
        ASF_STOP: begin
          if (s.rx_cnt == `ASF_OSR_LAST) begin
            next_s.rx_cnt = 6'h00;
            next_s.rx_ferr = s.rx_ferr | ~s.rx_s2; // [R15]
            // Only a two-stop setting checks a second bit; extra stops are idle
            if (stop == `ASF_STOP_2 && !s.rx_second) begin // [R14]
              next_s.rx_second = 1'b1;
            end else begin
              next_s.rx_st = ASF_IDLE; // [R13]
              next_s.frame_err = next_s.frame_err | s.rx_ferr | ~s.rx_s2; // [R15]
              next_s.par_err = next_s.par_err | s.rx_perr;
              // Corrupt characters never act as flow codes
              if (s.ctrl[`ASF_CTRL_FLOW] && !s.rx_perr && !s.rx_ferr && s.rx_s2 &&
                  rx_word == `ASF_DEVICE_CONTROL_THREE_CODE) begin
                next_s.paused = 1'b1; // [R16]
              end else if (s.ctrl[`ASF_CTRL_FLOW] && !s.rx_perr && !s.rx_ferr && s.rx_s2 &&
                           rx_word == `ASF_DEVICE_CONTROL_ONE_CODE) begin
                if (s.paused) next_s.paused = 1'b0; // [R17] [R18]
              end else begin
                // Flow codes are consumed; literal ones need flow off [R19]
                next_s.overrun = next_s.overrun | next_s.rx_valid;
                next_s.rx_data = rx_word;
                next_s.rx_valid = 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
      s.ctrl <= `ASF_CTRL_RST;
      s.tx_st <= ASF_IDLE;
      s.rx_st <= ASF_IDLE;
      s.tx_line <= 1'b1;
      s.rx_s1 <= 1'b1;
      s.rx_s2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

endmodule

//--- design/asf_peer.sv
// Peer end: framed serial transmitter and receiver with a plain user port.
// Assumes framing settings held steady by the user; no flow control here.
`timescale 1ns/1ps
`include "asf_defs.svh"

module asf_peer
  import asf_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Framing settings
  input wire logic [1:0] i_len,
  input wire logic [2:0] i_par,
  input wire logic [1:0] i_stop,
  input wire logic [15:0] i_div,
  // Transmit request
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  // Receive report
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_frame_err,
  output logic o_rx_par_err,
  // Serial link
  asf_link_if.peer lnk
);

  typedef struct packed {
    logic [15:0] baud_cnt;
    logic [7:0] tx_hold;
    logic tx_full;
    logic tx_ready;
    asf_state_t tx_st;
    logic [5:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic tx_line;
    logic rx_s1;
    logic rx_s2;
    asf_state_t rx_st;
    logic [5:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_perr;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_ferr_o;
    logic rx_perr_o;
  } asf_peer_st_t;

  asf_peer_st_t s;
  asf_peer_st_t next_s;

  logic tick;
  logic [2:0] last_bit;
  logic [7:0] rx_word;

  assign tick = (s.baud_cnt == 16'h0000);
  assign last_bit = {1'b0, i_len} + 3'h4;
  assign rx_word = s.rx_sh >> (2'h3 - i_len);

  assign o_tx_ready = s.tx_ready;
  assign o_rx_valid = s.rx_valid;
  assign o_rx_data = s.rx_data;
  assign o_rx_frame_err = s.rx_ferr_o;
  assign o_rx_par_err = s.rx_perr_o;
  assign lnk.p2d = s.tx_line;

  always_comb begin
    next_s = s;
    next_s.baud_cnt = tick ? i_div : s.baud_cnt - 16'h0001; // [R1]
    next_s.rx_valid = 1'b0;
    if (i_tx_valid && s.tx_ready) begin
      next_s.tx_hold = i_tx_data;
      next_s.tx_full = 1'b1;
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    if (tick) begin
      next_s.tx_cnt = s.tx_cnt + 6'h01;
      unique case (s.tx_st)
        ASF_IDLE: begin
          next_s.tx_line = 1'b1;
          next_s.tx_cnt = 6'h00;
          if (s.tx_full) begin
            next_s.tx_sh = s.tx_hold;
            next_s.tx_par = asf_parity(s.tx_hold, i_len, i_par); // [R7] [R8] [R10] [R11]
            next_s.tx_full = 1'b0;
            next_s.tx_st = ASF_START;
            next_s.tx_line = 1'b0; // [R3]
          end
        end
        ASF_START: begin
          if (s.tx_cnt == `ASF_OSR_LAST) begin // [R2]
            next_s.tx_cnt = 6'h00;
            next_s.tx_bit = 3'h0;
            next_s.tx_st = ASF_DATA;
            next_s.tx_line = s.tx_sh[0]; // [R5] [R6]
          end
        end
        ASF_DATA: begin
          if (s.tx_cnt == `ASF_OSR_LAST) begin
            next_s.tx_cnt = 6'h00;
            if (s.tx_bit == last_bit) begin // [R4]
              next_s.tx_st = (i_par == `ASF_PAR_NONE) ? ASF_STOP : ASF_PAR; // [R9]
              next_s.tx_line = (i_par == `ASF_PAR_NONE) ? 1'b1 : s.tx_par;
            end else begin
              next_s.tx_bit = s.tx_bit + 3'h1;
              next_s.tx_sh = {1'b0, s.tx_sh[7:1]};
              next_s.tx_line = s.tx_sh[1]; // [R6]
            end
          end
        end
        ASF_PAR: begin
          if (s.tx_cnt == `ASF_OSR_LAST) begin
            next_s.tx_cnt = 6'h00;
            next_s.tx_st = ASF_STOP;
            next_s.tx_line = 1'b1; // [R12]
          end
        end
        ASF_STOP: begin
          if (s.tx_cnt == asf_stop_last(i_stop)) begin // [R12]
            next_s.tx_cnt = 6'h00;
            next_s.tx_st = ASF_IDLE;
          end
        end
      endcase
    end
    next_s.tx_ready = ~next_s.tx_full;

    // ----------------------------------------
    // Receiver: one stop bit checked, further stops are idle
    // ----------------------------------------
    next_s.rx_s1 = lnk.d2p;
    next_s.rx_s2 = s.rx_s1;
    if (tick) begin
      next_s.rx_cnt = s.rx_cnt + 6'h01;
      unique case (s.rx_st)
        ASF_IDLE: begin
          next_s.rx_cnt = 6'h00;
          if (!s.rx_s2) next_s.rx_st = ASF_START;
        end
        ASF_START: begin
          if (s.rx_cnt == `ASF_HALF_LAST) begin
            next_s.rx_cnt = 6'h00;
            next_s.rx_bit = 3'h0;
            next_s.rx_perr = 1'b0;
            next_s.rx_st = s.rx_s2 ? ASF_IDLE : ASF_DATA;
          end
        end
        ASF_DATA: begin
          if (s.rx_cnt == `ASF_OSR_LAST) begin
            next_s.rx_cnt = 6'h00;
            next_s.rx_sh = {s.rx_s2, s.rx_sh[7:1]}; // [R6]
            next_s.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == last_bit) begin
              next_s.rx_st = (i_par == `ASF_PAR_NONE) ? ASF_STOP : ASF_PAR; // [R9]
            end
          end
        end
        ASF_PAR: begin
          if (s.rx_cnt == `ASF_OSR_LAST) begin
            next_s.rx_cnt = 6'h00;
            next_s.rx_perr = (s.rx_s2 != asf_parity(rx_word, i_len, i_par));
            next_s.rx_st = ASF_STOP;
          end
        end
        ASF_STOP: begin
          if (s.rx_cnt == `ASF_OSR_LAST) begin
            next_s.rx_cnt = 6'h00;
            next_s.rx_st = ASF_IDLE;
            next_s.rx_valid = 1'b1;
            next_s.rx_data = rx_word;
            next_s.rx_ferr_o = ~s.rx_s2; // [R12]
            next_s.rx_perr_o = s.rx_perr;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
      s.tx_st <= ASF_IDLE;
      s.rx_st <= ASF_IDLE;
      s.tx_line <= 1'b1;
      s.tx_ready <= 1'b1;
      s.rx_s1 <= 1'b1;
      s.rx_s2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

endmodule

//--- bench/asf_link_properties.sv
// Checker for both serial lines: bit timing, idle level, character length.
// Assumes an oversample divisor of 0 on both ends, so one bit is 16 clocks.
`timescale 1ns/1ps

module asf_link_properties (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Serial lines
  input wire logic d2p,
  input wire logic p2d
);
  // ----------------------------------------
  // Run-length counters
  // ----------------------------------------
  logic [7:0] lo_d, hi_d, lo_p, hi_p;

  // High runs saturate, so a long idle never wraps into a false short run
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lo_d <= 8'h00;
      lo_p <= 8'h00;
      hi_d <= 8'hff;
      hi_p <= 8'hff;
    end else begin
      lo_d <= d2p ? 8'h00 : lo_d + 8'h01;
      lo_p <= p2d ? 8'h00 : lo_p + 8'h01;
      hi_d <= !d2p ? 8'h00 : (hi_d == 8'hff ? hi_d : hi_d + 8'h01);
      hi_p <= !p2d ? 8'h00 : (hi_p == 8'hff ? hi_p : hi_p + 8'h01);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_dev_idle_reset: assert property ($fell(i_rst) |-> d2p)
    else $error("device line not idle after reset");
  a_peer_idle_reset: assert property ($fell(i_rst) |-> p2d)
    else $error("peer line not idle after reset");
  a_dev_low_whole: assert property ($rose(d2p) |-> lo_d != 8'h00 && lo_d[3:0] == 4'h0)
    else $error("device line low run not whole bits");
  a_peer_low_whole: assert property ($rose(p2d) |-> lo_p != 8'h00 && lo_p[3:0] == 4'h0)
    else $error("peer line low run not whole bits");
  a_dev_low_max: assert property (!d2p |-> lo_d < 8'ha0)
    else $error("device line low longer than a character");
  a_peer_low_max: assert property (!p2d |-> lo_p < 8'ha0)
    else $error("peer line low longer than a character");
  a_dev_start_gap: assert property ($fell(d2p) |-> hi_d >= 8'h10)
    else $error("device start without a full high bit");
  a_peer_start_gap: assert property ($fell(p2d) |-> hi_p >= 8'h10)
    else $error("peer start without a full high bit");
endmodule

//--- bench/async_serial_framing_flow_ctl_tb_top.sv
// Testbench: device end and peer end joined by the link interface.
// Assumes both ends run with oversample divisor 0 (16 clocks per bit).
`timescale 1ns/1ps
`include "asf_defs.svh"

module async_serial_framing_flow_ctl_tb_top;
  logic i_clk = 1'b0, i_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ptv = 1'b0;
  logic [7:0] adr = 8'h00, ptd = 8'h00, prd, pdat, d, m;
  logic [31:0] wdat = 32'h0000_0000, rdat, rd;
  logic ack, ptr, prv, pfe, ppe;
  logic [1:0] p_len = 2'h3, p_stop = 2'h0, perr;
  logic [2:0] p_par = 3'h0;
  logic [11:0] got;
  int n_mismatch = 0, compares = 0, seed = 94, pcnt = 0, k, lows;

  always #25 i_clk = ~i_clk;

  asf_link_if u_asf_link_if ();
  asf_dev u_asf_dev (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .lnk(u_asf_link_if.dev));
  asf_peer u_asf_peer (.i_clk(i_clk), .i_rst(i_rst), .i_len(p_len), .i_par(p_par),
    .i_stop(p_stop), .i_div(16'h0000), .i_tx_valid(ptv), .i_tx_data(ptd), .o_tx_ready(ptr),
    .o_rx_valid(prv), .o_rx_data(prd), .o_rx_frame_err(pfe), .o_rx_par_err(ppe),
    .lnk(u_asf_link_if.peer));
  asf_link_properties u_asf_link_properties (.i_clk(i_clk), .i_rst(i_rst),
    .d2p(u_asf_link_if.d2p), .p2d(u_asf_link_if.p2d));

  always @(posedge i_clk) begin
    if (prv === 1'b1) begin
      pcnt <= pcnt + 1;
      pdat <= prd;
      perr <= {pfe, ppe};
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [11:0] frame(input logic [7:0] dv, input int l, input int p);
    logic [11:0] f;
    logic [7:0] mv;
    mv = 8'hff >> (3 - l);
    f = 12'hffe;
    for (int i = 0; i < l + 5; i++) f[i + 1] = dv[i];
    if (p == 1) f[l + 6] = ~^(dv & mv);
    if (p == 2) f[l + 6] = ^(dv & mv);
    if (p == 4) f[l + 6] = 1'b0;
    return f;
  endfunction

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dv;
    do begin
      @(posedge i_clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    rd = rdat;
    if (ack !== 1'b1) n_mismatch++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge i_clk);
  endtask

  // Samples each bit at its centre, start bit first; no wait after the last
  task automatic grab(input logic side, input int n);
    int t;
    t = 0;
    got = 12'hfff;
    while ((side ? u_asf_link_if.p2d : u_asf_link_if.d2p) !== 1'b0 && t < 3000) begin
      @(posedge i_clk);
      t++;
    end
    if (t >= 3000) n_mismatch++;
    repeat (8) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      got[i] = side ? u_asf_link_if.p2d : u_asf_link_if.d2p;
      if (i < n - 1) repeat (16) @(posedge i_clk);
    end
  endtask

  task automatic send(input logic [7:0] dv);
    int t = 0;
    ptv <= 1'b1;
    ptd <= dv;
    do begin
      @(posedge i_clk);
      t++;
    end while (ptr !== 1'b1 && t < 400);
    if (ptr !== 1'b1) n_mismatch++;
    ptv <= 1'b0;
  endtask

  task automatic dtx(input logic [7:0] dv, input logic [11:0] x, input int n);
    fork
      grab(1'b0, n);
      wb(1'b1, `ASF_ADR_TXDATA, {24'h00_0000, dv});
    join
    chk("device line frame", x, got);
    repeat (16) @(posedge i_clk);
  endtask

  task automatic ptx(input logic [7:0] dv, input logic [11:0] x, input int n);
    fork
      grab(1'b1, n);
      send(dv);
    join
    chk("peer line frame", x, got);
    repeat (16) @(posedge i_clk);
  endtask

  task automatic finish_test();
    $display("mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    wb(1'b0, `ASF_ADR_CTRL, 32'h0000_0000);
    chk("ctrl reset", `ASF_CTRL_RST, rd);
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
    // Every length, parity mode and stop length, both directions
    for (int l = 0; l < 4; l++) begin
      for (int p = 0; p < 5; p++) begin
        for (int s = 0; s < 3; s++) begin
          m = 8'hff >> (3 - l);
          wb(1'b1, `ASF_ADR_CTRL, {24'h00_0000, 1'b0, 2'(s), 3'(p), 2'(l)});
          p_len <= 2'(l);
          p_par <= 3'(p);
          p_stop <= 2'(s);
          d = 8'($random(seed));
          k = pcnt;
          dtx(d, frame(d, l, p), l + 7 + (p != 0) + (s == 2));
          chk("peer rx count", k + 1, pcnt);
          chk("peer rx data", {24'h00_0000, d & m}, pdat);
          chk("peer rx errors", 32'h0000_0000, perr);
          d = 8'($random(seed));
          ptx(d, frame(d, l, p), l + 7 + (p != 0) + (s == 2));
          wb(1'b0, `ASF_ADR_STATUS, 32'h0000_0000);
          chk("device rx status", 32'h0000_0008, rd & 32'h0000_0078);
          wb(1'b0, `ASF_ADR_RXDATA, 32'h0000_0000);
          chk("device rx data", {24'h00_0000, d & m}, rd);
        end
      end
    end
    // Flow control, 8 data bits, no parity, one stop
    p_len <= 2'h3;
    p_par <= 3'h0;
    p_stop <= 2'h0;
    wb(1'b1, `ASF_ADR_CTRL, 32'h0000_0083);
    ptx(`ASF_DEVICE_CONTROL_ONE_CODE, frame(8'h11, 3, 0), 10);
    wb(1'b0, `ASF_ADR_STATUS, 32'h0000_0000);
    chk("resume while running", 32'h0000_0000, rd & 32'h0000_000c);
    ptx(`ASF_DEVICE_CONTROL_THREE_CODE, frame(8'h13, 3, 0), 10);
    wb(1'b0, `ASF_ADR_STATUS, 32'h0000_0000);
    chk("paused status", 32'h0000_0004, rd & 32'h0000_000c);
    d = 8'h3c;
    k = pcnt;
    wb(1'b1, `ASF_ADR_TXDATA, {24'h00_0000, d});
    lows = 0;
    repeat (300) begin
      @(posedge i_clk);
      if (u_asf_link_if.d2p !== 1'b1) lows++;
    end
    chk("line while paused", 32'h0000_0000, lows);
    fork
      grab(1'b0, 10);
      ptx(`ASF_DEVICE_CONTROL_ONE_CODE, frame(8'h11, 3, 0), 10);
    join
    chk("held byte after resume", frame(d, 3, 0), got);
    repeat (32) @(posedge i_clk);
    chk("peer got held byte", {24'h00_0000, d}, pdat);
    // Two stop bits sent, one expected: both characters accepted
    p_stop <= 2'h2;
    fork
      begin
        send(8'h5a);
        @(posedge i_clk);
        send(8'ha5);
      end
      begin
        grab(1'b1, 11);
        grab(1'b1, 11);
      end
    join
    repeat (16) @(posedge i_clk);
    wb(1'b0, `ASF_ADR_STATUS, 32'h0000_0000);
    chk("two stop errors", 32'h0000_0040, rd & 32'h0000_0050);
    wb(1'b0, `ASF_ADR_RXDATA, 32'h0000_0000);
    chk("two stop last data", 32'h0000_00a5, rd);
    // Short odd-parity setting: parity and stop sampled low, then cleared
    p_stop <= 2'h0;
    wb(1'b1, `ASF_ADR_CTRL, 32'h0000_0004);
    ptx(8'h00, frame(8'h00, 3, 0), 10);
    wb(1'b0, `ASF_ADR_STATUS, 32'h0000_0000);
    chk("line errors", 32'h0000_0030, rd & 32'h0000_0030);
    repeat (120) @(posedge i_clk);
    wb(1'b1, `ASF_ADR_STATUS, 32'h0000_0030);
    wb(1'b0, `ASF_ADR_STATUS, 32'h0000_0000);
    chk("line errors cleared", 32'h0000_0000, rd & 32'h0000_0030);
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge i_clk);
    n_mismatch++;
    finish_test();
  end
endmodule
